/* File: src/fvic_consts.vh */
// Constants for the four-level vectored interrupt controller.
// Assumes an 8-bit register port and a single system clock.
`ifndef FVIC_CONSTS_VH
`define FVIC_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define FVIC_ADDR_EN_PRI 8'ha8
`define FVIC_ADDR_EN_SEC 8'he8
`define FVIC_ADDR_PRIO_LO 8'hb8
`define FVIC_ADDR_PRIO_HI 8'hb7
`define FVIC_ADDR_STATUS 8'hc0
`define FVIC_ADDR_SVC 8'hc1

// ****************************************************************
// Field positions
// ****************************************************************
`define FVIC_BIT_GLOBAL 7
`define FVIC_BIT_CNT_ARRAY 6
`define FVIC_BIT_TIMER2 5
`define FVIC_BIT_SERIAL 4
`define FVIC_BIT_TIMER1 3
`define FVIC_BIT_EXT1 2
`define FVIC_BIT_TIMER0 1
`define FVIC_BIT_EXT0 0
`define FVIC_BIT_CONV 1

// ****************************************************************
// Reset values
// ****************************************************************
`define FVIC_RST_EN_PRI 8'h00
`define FVIC_RST_EN_SEC 8'h00
`define FVIC_RST_PRIO 8'h00

// ****************************************************************
// Source indexes in polling order (0 polled first)
// ****************************************************************
`define FVIC_SRC_EXT0 0
`define FVIC_SRC_TIMER0 1
`define FVIC_SRC_EXT1 2
`define FVIC_SRC_TIMER1 3
`define FVIC_SRC_CNT_ARRAY 4
`define FVIC_SRC_SERIAL 5
`define FVIC_SRC_TIMER2 6
`define FVIC_SRC_CONV 7

// ****************************************************************
// Vector addresses
// ****************************************************************
`define FVIC_VEC_EXT0 16'h0003
`define FVIC_VEC_TIMER0 16'h000b
`define FVIC_VEC_EXT1 16'h0013
`define FVIC_VEC_TIMER1 16'h001b
`define FVIC_VEC_SERIAL 16'h0023
`define FVIC_VEC_TIMER2 16'h002b
`define FVIC_VEC_CNT_ARRAY 16'h0033
`define FVIC_VEC_CONV 16'h0043

`endif

/* File: src/fvic_sync.v */
// Two-stage synchroniser for a bus of asynchronous inputs.
// Assumes clk is the system clock; ce freezes the stages.
module fvic_sync #(
  parameter W = 2
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  input wire ce,
  // Data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule // fvic_sync

/* File: src/fvic_ctrl.v */
// Four-level vectored interrupt controller for an 8-bit core.
// Assumes peripheral flags on clk, external pins asynchronous,
// and a core that acknowledges each vector and signals returns.
//
// Summary of operation
// - Eight sources: ext 0-1, timers 0-2, serial, counter array, converter.
// - A clear global enable blocks every source at once.
// - With global enable bit 7 set, each source follows its own enable.
// - Primary bits: array 6, t2 5, serial 4, t1 3, ext1 2, t0 1, ext0 0.
// - Secondary enable bit 1 permits the converter request.
// - Level is high bit and low bit: 00 lowest through 11 highest.
// - A handler is preempted only by a strictly higher level.
// - A level 3 handler is never preempted.
// - Of simultaneous requests the higher level is served first.
// - Equal levels go by fixed polling order, ext 0 first, converter last.
// - Vectors 0003h, 000Bh, 0013h, 001Bh, 0023h, 002Bh, 0033h, 0043h.
// - Primary enable resets to zero and allows single-bit writes.
// - The converter source is its end-of-conversion flag, set by hardware.
`include "fvic_consts.vh"

module fvic_ctrl (
  // Clock, reset, enable
  input wire clk,
  input wire rst,
  input wire ce,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire bit_wr,
  input wire [2:0] bit_sel,
  output reg [7:0] reg_rdata,
  // External request pins, asynchronous
  input wire ext_request_pin_0,
  input wire ext_request_pin_1,
  // Peripheral request flags, on clk
  input wire timer0_overflow_flag,
  input wire timer1_overflow_flag,
  input wire timer2_overflow_flag,
  input wire serial_receive_flag,
  input wire serial_transmit_flag,
  input wire counter_array_overflow_flag,
  input wire counter_array_module_flag,
  input wire conversion_done_flag,
  // Core side
  input wire irq_ack,
  input wire irq_return,
  output reg irq_req,
  output reg [15:0] irq_vector,
  output reg [2:0] irq_source,
  output reg [1:0] irq_level
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Level from priority high and low bits
  function [1:0] prio_level;
    input hi;
    input lo;
    begin
      prio_level = {hi, lo};
    end
  endfunction

  // Vector for a source index
  function [15:0] src_vector;
    input [2:0] s;
    begin
      case (s)
        `FVIC_SRC_EXT0: src_vector = `FVIC_VEC_EXT0;
        `FVIC_SRC_TIMER0: src_vector = `FVIC_VEC_TIMER0;
        `FVIC_SRC_EXT1: src_vector = `FVIC_VEC_EXT1;
        `FVIC_SRC_TIMER1: src_vector = `FVIC_VEC_TIMER1;
        `FVIC_SRC_CNT_ARRAY: src_vector = `FVIC_VEC_CNT_ARRAY;
        `FVIC_SRC_SERIAL: src_vector = `FVIC_VEC_SERIAL;
        `FVIC_SRC_TIMER2: src_vector = `FVIC_VEC_TIMER2;
        default: src_vector = `FVIC_VEC_CONV;
      endcase
    end
  endfunction

  // Register update that honours byte and single-bit writes
  function [7:0] reg_write;
    input [7:0] old;
    input [7:0] wdata;
    input bw;
    input [2:0] sel;
    reg [7:0] mask;
    begin
      mask = 8'h01 << sel;
      if (bw) begin
        reg_write = (old & ~mask) | ({8{wdata[0]}} & mask);
      end else begin
        reg_write = wdata;
      end
    end
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [7:0] en_pri_reg;
  reg [7:0] en_sec_reg;
  reg [7:0] prio_lo_reg;
  reg [7:0] prio_hi_reg;
  reg [3:0] in_svc_reg;
  reg [7:0] flag_q_reg;

  wire [1:0] ext_sync;

  // ****************************************************************
  // Write selects: a byte or a single-bit write to one register
  // ****************************************************************
  wire any_wr = reg_wr | bit_wr;
  wire sel_pri = any_wr & (reg_addr == `FVIC_ADDR_EN_PRI);
  wire sel_sec = any_wr & (reg_addr == `FVIC_ADDR_EN_SEC);
  wire sel_plo = any_wr & (reg_addr == `FVIC_ADDR_PRIO_LO);
  wire sel_phi = any_wr & (reg_addr == `FVIC_ADDR_PRIO_HI);

  fvic_sync #(
    .W(2)
  ) u_ext_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d({ext_request_pin_1, ext_request_pin_0}),
    .q(ext_sync)
  );

  // ****************************************************************
  // Request flags, indexed in polling order
  // ****************************************************************
  wire [7:0] flags;
  assign flags[`FVIC_SRC_EXT0] = ext_sync[0];
  assign flags[`FVIC_SRC_TIMER0] = timer0_overflow_flag;
  assign flags[`FVIC_SRC_EXT1] = ext_sync[1];
  assign flags[`FVIC_SRC_TIMER1] = timer1_overflow_flag;
  assign flags[`FVIC_SRC_CNT_ARRAY] =
    counter_array_overflow_flag | counter_array_module_flag;
  assign flags[`FVIC_SRC_SERIAL] =
    serial_receive_flag | serial_transmit_flag;
  assign flags[`FVIC_SRC_TIMER2] = timer2_overflow_flag;
  assign flags[`FVIC_SRC_CONV] = conversion_done_flag;

  // Per-source enables, in polling order
  wire [7:0] src_en;
  assign src_en[`FVIC_SRC_EXT0] = en_pri_reg[`FVIC_BIT_EXT0];
  assign src_en[`FVIC_SRC_TIMER0] = en_pri_reg[`FVIC_BIT_TIMER0];
  assign src_en[`FVIC_SRC_EXT1] = en_pri_reg[`FVIC_BIT_EXT1];
  assign src_en[`FVIC_SRC_TIMER1] = en_pri_reg[`FVIC_BIT_TIMER1];
  assign src_en[`FVIC_SRC_CNT_ARRAY] = en_pri_reg[`FVIC_BIT_CNT_ARRAY];
  assign src_en[`FVIC_SRC_SERIAL] = en_pri_reg[`FVIC_BIT_SERIAL];
  assign src_en[`FVIC_SRC_TIMER2] = en_pri_reg[`FVIC_BIT_TIMER2];
  assign src_en[`FVIC_SRC_CONV] = en_sec_reg[`FVIC_BIT_CONV];

  wire global_irq_enable = en_pri_reg[`FVIC_BIT_GLOBAL];

  // Offered requests
  wire [7:0] offered =
    flags & src_en & {8{global_irq_enable}};

  // Level of each source, in polling order
  wire [15:0] src_lvl;
  assign src_lvl[1:0] = prio_level(prio_hi_reg[0], prio_lo_reg[0]);
  assign src_lvl[3:2] = prio_level(prio_hi_reg[1], prio_lo_reg[1]);
  assign src_lvl[5:4] = prio_level(prio_hi_reg[2], prio_lo_reg[2]);
  assign src_lvl[7:6] = prio_level(prio_hi_reg[3], prio_lo_reg[3]);
  assign src_lvl[9:8] = prio_level(prio_hi_reg[4], prio_lo_reg[4]);
  assign src_lvl[11:10] = prio_level(prio_hi_reg[5], prio_lo_reg[5]);
  assign src_lvl[13:12] = prio_level(prio_hi_reg[6], prio_lo_reg[6]);
  assign src_lvl[15:14] = prio_level(prio_hi_reg[7], prio_lo_reg[7]);

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  reg [1:0] best_lvl;
  reg [2:0] best_src;
  reg best_vld;
  reg [1:0] lvl_i;
  reg [1:0] cur_lvl;
  reg cur_busy;
  integer i;

  always @* begin
    best_lvl = 2'b00;
    best_src = 3'd0;
    best_vld = 1'b0;
    lvl_i = 2'b00;
    // Strictly greater keeps the earlier polled source on ties
    for (i = 0; i < 8; i = i + 1) begin
      lvl_i = src_lvl[2*i +: 2];
      if (offered[i] && (!best_vld || lvl_i > best_lvl)) begin
        best_vld = 1'b1;
        best_lvl = lvl_i;
        best_src = i[2:0];
      end
    end
  end

  // Highest level now in service
  always @* begin
    cur_busy = |in_svc_reg;
    cur_lvl = 2'b00;
    if (in_svc_reg[3]) begin
      cur_lvl = 2'b11;
    end else if (in_svc_reg[2]) begin
      cur_lvl = 2'b10;
    end else if (in_svc_reg[1]) begin
      cur_lvl = 2'b01;
    end
  end

  // Only a strictly higher level may preempt; level 3 never loses
  wire can_take =
    best_vld && (!cur_busy || best_lvl > cur_lvl);

  // ****************************************************************
  // Register writes and in-service tracking
  // ****************************************************************
  reg [3:0] svc_next;
  wire taken = irq_ack & irq_req;

  always @* begin
    svc_next = in_svc_reg;
    // Release the top level on return
    if (irq_return) begin
      if (in_svc_reg[3]) begin
        svc_next[3] = 1'b0;
      end else if (in_svc_reg[2]) begin
        svc_next[2] = 1'b0;
      end else if (in_svc_reg[1]) begin
        svc_next[1] = 1'b0;
      end else begin
        svc_next[0] = 1'b0;
      end
    end
    // Acknowledge claims the offered level; set wins over release
    if (taken) begin
      svc_next[irq_level] = 1'b1;
    end
  end

  // Enable and priority registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      en_pri_reg <= `FVIC_RST_EN_PRI;
    end else if (ce && sel_pri) begin
      en_pri_reg <= reg_write(en_pri_reg, reg_wdata, bit_wr,
        bit_sel);
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      en_sec_reg <= `FVIC_RST_EN_SEC;
    end else if (ce && sel_sec) begin
      en_sec_reg <= reg_write(en_sec_reg, reg_wdata, bit_wr,
        bit_sel);
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prio_lo_reg <= `FVIC_RST_PRIO;
    end else if (ce && sel_plo) begin
      prio_lo_reg <= reg_write(prio_lo_reg, reg_wdata, bit_wr,
        bit_sel);
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prio_hi_reg <= `FVIC_RST_PRIO;
    end else if (ce && sel_phi) begin
      prio_hi_reg <= reg_write(prio_hi_reg, reg_wdata, bit_wr,
        bit_sel);
    end
  end

  // In-service levels and latched offered requests
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      in_svc_reg <= 4'h0;
      flag_q_reg <= 8'h00;
    end else if (ce) begin
      in_svc_reg <= svc_next;
      flag_q_reg <= offered;
    end
  end

  // ****************************************************************
  // Core outputs
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_req <= 1'b0;
      irq_vector <= 16'h0000;
      irq_source <= 3'd0;
      irq_level <= 2'b00;
    end else if (ce) begin
      // Drop the request in the cycle after acknowledge
      if (taken) begin
        irq_req <= 1'b0;
      end else begin
        irq_req <= can_take;
        if (can_take) begin
          irq_vector <= src_vector(best_src);
          irq_source <= best_src;
          irq_level <= best_lvl;
        end
      end
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      if (reg_rd) begin
        case (reg_addr)
          `FVIC_ADDR_EN_PRI: reg_rdata <= en_pri_reg;
          `FVIC_ADDR_EN_SEC: reg_rdata <= en_sec_reg;
          `FVIC_ADDR_PRIO_LO: reg_rdata <= prio_lo_reg;
          `FVIC_ADDR_PRIO_HI: reg_rdata <= prio_hi_reg;
          `FVIC_ADDR_STATUS: reg_rdata <= flag_q_reg;
          `FVIC_ADDR_SVC: reg_rdata <= {4'h0, in_svc_reg};
          default: reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule // fvic_ctrl

/* File: tb/fvic_core_model.sv */
// Core model: takes offered vectors and signals handler returns.
// Assumes the bench gates taking with take_en and pulses ret_cmd.
module fvic_core_model (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Controller side
  input wire irq_req,
  input wire [2:0] irq_source,
  output reg irq_ack,
  output reg irq_return,
  // Bench side
  input wire take_en,
  input wire ret_cmd,
  output reg [2:0] got_src,
  output reg [7:0] got_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      got_src <= 3'h0;
      got_cnt <= 8'h00;
    end else begin
      irq_ack <= irq_req && take_en && !irq_ack;
      irq_return <= ret_cmd;
      if (irq_req && irq_ack) begin
        got_src <= irq_source;
        got_cnt <= got_cnt + 8'h01;
      end
    end
  end
endmodule // fvic_core_model

/* File: tb/fvic_ctrl_assertions.sv */
// Port checker for the interrupt controller, bound to its top.
// Assumes the shadow state follows the design only while ce is high.
module fvic_ctrl_assertions (
  // Clock and reset
  input wire clk,
  input wire rst,
  input wire ce,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire bit_wr,
  input wire [2:0] bit_sel,
  input wire [7:0] reg_rdata,
  // Peripheral flags
  input wire timer0_overflow_flag,
  input wire timer1_overflow_flag,
  input wire timer2_overflow_flag,
  input wire serial_receive_flag,
  input wire serial_transmit_flag,
  input wire counter_array_overflow_flag,
  input wire counter_array_module_flag,
  input wire conversion_done_flag,
  // Core side
  input wire irq_ack,
  input wire irq_return,
  input wire irq_req,
  input wire [15:0] irq_vector,
  input wire [2:0] irq_source,
  input wire [1:0] irq_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Shadow of primary enable and in-service levels
  // ****************************************************************
  wire [127:0] vt = {16'h0043, 16'h002b, 16'h0023, 16'h0033,
    16'h001b, 16'h0013, 16'h000b, 16'h0003};
  wire [7:0] flagv = {conversion_done_flag, timer2_overflow_flag,
    serial_receive_flag | serial_transmit_flag,
    counter_array_overflow_flag | counter_array_module_flag,
    timer1_overflow_flag, 1'b0, timer0_overflow_flag, 1'b0};
  reg [7:0] en_reg;
  reg [3:0] svc_reg;
  reg [3:0] svc_next;
  // Highest level in service plus one, zero when idle
  wire [2:0] top = svc_reg[3] ? 3'd4 : svc_reg[2] ? 3'd3 :
    svc_reg[1] ? 3'd2 : {2'b00, svc_reg[0]};
  always @* begin
    svc_next = svc_reg;
    if (irq_return && top != 3'd0)
      svc_next[top - 3'd1] = 1'b0;
    if (irq_req && irq_ack)
      svc_next[irq_level] = 1'b1;
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      en_reg <= 8'h00;
      svc_reg <= 4'h0;
    end else if (ce) begin
      svc_reg <= svc_next;
      if (reg_wr && reg_addr == 8'ha8)
        en_reg <= reg_wdata;
      else if (bit_wr && reg_addr == 8'ha8)
        en_reg[bit_sel] <= reg_wdata[0];
    end
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_taken;
    irq_req && irq_ack;
  endsequence
  sequence s_read_pri;
    reg_rd && reg_addr == 8'ha8;
  endsequence
  a_ack_drop: assert property (s_taken |=> !irq_req)
    else $error("request stays after ack");
  a_strict_preempt: assert property (
    irq_req |-> {1'b0, irq_level} >= top)
    else $error("request not above level in service");
  a_level3_block: assert property (svc_reg[3] |-> !irq_req)
    else $error("request during top level handler");
  a_global_gate: assert property (!en_reg[7] |=> !irq_req)
    else $error("request with global enable clear");
  a_vector_map: assert property (
    irq_req |-> irq_vector == vt[{irq_source, 4'h0} +: 16])
    else $error("vector does not match source");
  a_needs_flag: assert property (
    irq_req && irq_source != 3'd0 && irq_source != 3'd2 |->
    (($past(flagv) >> irq_source) & 8'h01) != 8'h00)
    else $error("request without its flag");
  a_enable_read: assert property (
    s_read_pri |=> reg_rdata == $past(en_reg))
    else $error("enable readback differs");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule // fvic_ctrl_assertions

bind fvic_ctrl fvic_ctrl_assertions fvic_ctrl_assertions_i (.clk, .rst, .ce,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .bit_wr, .bit_sel, .reg_rdata,
  .timer0_overflow_flag, .timer1_overflow_flag, .timer2_overflow_flag,
  .serial_receive_flag, .serial_transmit_flag, .counter_array_overflow_flag,
  .counter_array_module_flag, .conversion_done_flag, .irq_ack, .irq_return,
  .irq_req, .irq_vector, .irq_source, .irq_level);

/* File: tb/fvic_ctrl_tb.sv */
// Self-checking bench for the interrupt controller.
// Assumes the core model acks offered requests while take_en is high.
module fvic_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic bit_wr = 1'b0;
  logic alt = 1'b0;
  logic take_en = 1'b0;
  logic ret_cmd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] fl = 8'h00;
  logic [2:0] bit_sel = 3'h0;
  logic [47:0] r;
  wire [7:0] reg_rdata;
  wire [7:0] got_cnt;
  wire [15:0] irq_vector;
  wire [2:0] irq_source;
  wire [2:0] got_src;
  wire [1:0] irq_level;
  wire irq_req;
  wire irq_ack;
  wire irq_return;
  int fail_count = 0;
  int checks_done = 0;
  logic [127:0] vt = {16'h0043, 16'h002b, 16'h0023, 16'h0033,
    16'h001b, 16'h0013, 16'h000b, 16'h0003};
  // Rows: primary, secondary, prio low, prio high, flags, {req,level,src}
  logic [47:0] rows [21] = '{
    48'h00000000ff00, 48'h7f020000ff00, 48'h810000000200,
    48'h810000000180, 48'h820000000281, 48'h840000000482,
    48'h880000000883, 48'hc00000001084, 48'h900000002085,
    48'ha00000004086, 48'h800200008087, 48'h800000008000,
    48'h000200008000, 48'hff020000ff80, 48'hff020000fe81,
    48'hff028000ffa7, 48'hff028040ffc6, 48'hff02c040ffe6,
    48'hff020020ffc5, 48'hff022800ffa3, 48'hff020000f084};
  fvic_ctrl fvic_ctrl_i (.clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .bit_wr, .bit_sel, .reg_rdata, .ext_request_pin_0(fl[0]),
    .ext_request_pin_1(fl[2]), .timer0_overflow_flag(fl[1]),
    .timer1_overflow_flag(fl[3]), .timer2_overflow_flag(fl[6]),
    .serial_receive_flag(fl[5] & ~alt), .serial_transmit_flag(fl[5] & alt),
    .counter_array_overflow_flag(fl[4] & ~alt),
    .counter_array_module_flag(fl[4] & alt),
    .conversion_done_flag(fl[7]), .irq_ack, .irq_return, .irq_req,
    .irq_vector, .irq_source, .irq_level);
  fvic_core_model fvic_core_model_i (.clk, .rst, .irq_req, .irq_source,
    .irq_ack, .irq_return, .take_en, .ret_cmd, .got_src, .got_cnt);
  always #5 clk = ~clk;
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, d, input logic b,
    input logic [2:0] s);
    reg_addr <= a;
    reg_wdata <= d;
    bit_sel <= s;
    reg_wr <= ~b;
    bit_wr <= b;
    @(posedge clk);
    reg_wr <= 1'b0;
    bit_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, e, input string n);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(n, {8'h00, e}, {8'h00, reg_rdata});
    @(posedge clk);
  endtask
  task automatic ret();
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
  endtask
  // Waits a bounded time for the core to take a vector
  task automatic take(input logic e, input logic [2:0] s);
    logic [7:0] c;
    c = got_cnt;
    for (int k = 0; k < 20 && got_cnt == c; k++)
      @(negedge clk);
    chk("taken", {15'h0, e}, {8'h00, got_cnt - c});
    if (e)
      chk("got_src", {13'h0, s}, {13'h0, got_src});
    @(posedge clk);
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'ha8, 8'h00, "irq_enable_primary");
    rd(8'he8, 8'h00, "irq_enable_secondary");
    rd(8'h10, 8'h00, "unmapped");
    wr(8'ha8, 8'h01, 1'b1, 3'h7);
    rd(8'ha8, 8'h80, "irq_enable_primary");
    for (int i = 0; i < 21; i++) begin
      r = rows[i];
      wr(8'ha8, r[47:40], 1'b0, 3'h0);
      wr(8'he8, r[39:32], 1'b0, 3'h0);
      wr(8'hb8, r[31:24], 1'b0, 3'h0);
      wr(8'hb7, r[23:16], 1'b0, 3'h0);
      alt <= i[0];
      fl <= r[15:8];
      repeat (5) @(posedge clk);
      chk("irq_req", {15'h0, r[7]}, {15'h0, irq_req});
      if (r[7]) begin
        chk("irq_vector", vt[{r[2:0], 4'h0} +: 16], irq_vector);
        chk("irq_level", {14'h0, r[6:5]}, {14'h0, irq_level});
        chk("irq_source", {13'h0, r[2:0]}, {13'h0, irq_source});
      end
      fl <= 8'h00;
      repeat (3) @(posedge clk);
    end
    wr(8'ha8, 8'hff, 1'b0, 3'h0);
    wr(8'he8, 8'h02, 1'b0, 3'h0);
    wr(8'hb8, 8'h0a, 1'b0, 3'h0);
    wr(8'hb7, 8'h08, 1'b0, 3'h0);
    take_en <= 1'b1;
    fl <= 8'h01;
    take(1'b1, 3'h0);
    fl <= 8'h03;
    take(1'b1, 3'h1);
    fl <= 8'h07;
    take(1'b0, 3'h0);
    fl <= 8'h0f;
    take(1'b1, 3'h3);
    rd(8'hc1, 8'h0b, "in_service");
    rd(8'hc0, 8'h0f, "offered");
    fl <= 8'hff;
    take(1'b0, 3'h0);
    fl <= 8'hf7;
    ret();
    take(1'b0, 3'h0);
    ret();
    take(1'b1, 3'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'ha8, 8'h00, "irq_enable_primary");
    ce <= 1'b0;
    wr(8'ha8, 8'h81, 1'b0, 3'h0);
    ce <= 1'b1;
    rd(8'ha8, 8'h00, "frozen_enable");
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
endmodule // fvic_ctrl_tb
